//--- src/shb_regs.vh
`ifndef SHB_REGS_VH
`define SHB_REGS_VH
// ****************************************
// Control word fields
// ****************************************
`define SHB_WORD_W        16
`define SHB_CW_CLR_BIT    0
`define SHB_CW_SW_LSB     1
`define SHB_CW_SW_MSB     12
`define SHB_CW_OCSD_BIT   13
`define SHB_CW_SUPPLY_HIGH_CUTOFF_BIT   15
// ****************************************
// Status word fields
// ****************************************
`define SHB_ST_TEMP_BIT   0
`define SHB_ST_OVL_BIT    13
`define SHB_ST_UNL_BIT    14
`define SHB_ST_SUP_BIT    15
// ****************************************
// Reset values
// ****************************************
`define SHB_CW_RESET      16'h0000
`define SHB_ST_RESET      16'h0000
// ****************************************
// Timing, nanoseconds and clock
// ****************************************
`define SHB_CLK_NS        5
`define SHB_OC_DELAY_NS   50000
`define SHB_UL_BLANK_NS   300000
`define SHB_LS_DELAY_NS   1000
`endif

//--- src/shb_sync.v
`timescale 1ns/10ps
// Three-stage synchroniser; output changes once stages two and three agree
module shb_sync #(
   parameter [0:0] RST_VAL = 1'b0
) (
   input  wire clock_in,
   input  wire rst_in,
   input  wire d_in,
   output reg  q_out
);
   reg s1_ff;
   reg s2_ff;
   reg s3_ff;
   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         s1_ff <= RST_VAL;
         s2_ff <= RST_VAL;
         s3_ff <= RST_VAL;
         q_out <= RST_VAL;
      end else begin
         s1_ff <= d_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         if (s2_ff == s3_ff) begin
            q_out <= s3_ff;
         end
      end
   end
endmodule

//--- src/shb_timer.v
`timescale 1ns/10ps
// Restartable down-counter; done_out high once the count has elapsed
module shb_timer #(
   parameter WIDTH = 16,
   parameter COUNT = 10
) (
   input  wire             clock_in,
   input  wire             rst_in,
   input  wire             start_in,
   input  wire             run_in,
   output wire             done_out
);
   reg [WIDTH-1:0] cnt_ff;
   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_ff <= {WIDTH{1'b0}};
      end else if (!run_in) begin
         cnt_ff <= {WIDTH{1'b0}};
      end else if (start_in) begin
         cnt_ff <= COUNT[WIDTH-1:0];
      end else if (cnt_ff != {WIDTH{1'b0}}) begin
         cnt_ff <= cnt_ff - {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end
   assign done_out = (cnt_ff == {WIDTH{1'b0}});
endmodule

//--- src/shb_core.v
`timescale 1ns/10ps
`include "shb_regs.vh"
// Behaviour
// - Falling chip select starts a frame of exactly sixteen control bits.
// - Serial input bits captured on rising serial clock, detected after synchronisers in the system clock domain.
// - During a frame, previous status word shifts out on serial output.
// - Rising chip select loads shifted word into the active control register.
// - Control bit 0 high clears status after each programming cycle.
// - Bits 1..12 drive switches; odd low-side, even high-side, ascending pairs.
// - Overcurrent held for cutoff delay turns switch off and latches overload.
// - Control bit 13 low suppresses the timed overcurrent shutdown.
// - Shared underload blanking timer restarts on each rising chip select.
// - Underload seen while blanking runs is never latched.
// - Low-side turn-on delayed so high-side is off first in a pair.
// - Control bit 15 high cuts all switch outputs on supply overvoltage; driver enable stays high.
// - Status: temp warning, switch states, overload, underload, supply fault.
// - Supply undervoltage holds every switch output in high impedance; the serial output is still driven during a frame.
// - Serial output released to high impedance while chip select is high.
// - Supply fault bit also set whenever control bit 15 is low.
// - Sleep input low clears all control and status and tristates outputs.
module shb_core #(
   parameter OC_CYCLES = `SHB_OC_DELAY_NS / `SHB_CLK_NS,
   parameter UL_CYCLES = `SHB_UL_BLANK_NS / `SHB_CLK_NS,
   parameter LS_CYCLES = (`SHB_LS_DELAY_NS + `SHB_CLK_NS - 1) / `SHB_CLK_NS
) (
   input  wire        clock_in,
   input  wire        rst_in,
   input  wire        chip_select_line_n_in,
   input  wire        serial_clock_in,
   input  wire        serial_in_line_in,
   input  wire        sleep_input_n_in,
   input  wire [5:0]  low_side_overcurrent_in,
   input  wire [5:0]  high_side_overcurrent_in,
   input  wire [5:0]  low_side_underload_in,
   input  wire [5:0]  high_side_underload_in,
   input  wire        temp_prewarn_in,
   input  wire        supply_over_in,
   input  wire        supply_under_in,
   output reg         serial_out_line_out,
   output wire        serial_out_line_oe_out,
   output reg  [5:0]  low_side_switch_out,
   output reg  [5:0]  high_side_switch_out,
   output reg         driver_enable_out
);
   // ****************************************
   // Helper functions
   // ****************************************
   // Interleave per-pair signals into control word order, low side first
   function [11:0] pair_mix;
      input [5:0] hs;
      input [5:0] ls;
      integer k;
      begin
         pair_mix = 12'h000;
         for (k = 0; k < 6; k = k + 1) begin
            pair_mix[2*k]   = ls[k];
            pair_mix[2*k+1] = hs[k];
         end
      end
   endfunction

   // Sticky flag: a new event wins over the clear of a programming cycle
   function sticky_bit;
      input held;
      input seen;
      input clear;
      begin
         sticky_bit = seen | (held & ~clear);
      end
   endfunction

   // ****************************************
   // Pin synchronisers
   // ****************************************
   wire cs_n_s;
   wire sck_s;
   wire sdi_s;
   wire slp_n_s;
   // Select resets high so no false frame start follows reset
   shb_sync #(.RST_VAL(1'b1)) u_cs (
      .clock_in(clock_in), .rst_in(rst_in),
      .d_in(chip_select_line_n_in), .q_out(cs_n_s));
   shb_sync #(.RST_VAL(1'b0)) u_sck (
      .clock_in(clock_in), .rst_in(rst_in),
      .d_in(serial_clock_in), .q_out(sck_s));
   shb_sync #(.RST_VAL(1'b0)) u_sdi (
      .clock_in(clock_in), .rst_in(rst_in),
      .d_in(serial_in_line_in), .q_out(sdi_s));
   shb_sync #(.RST_VAL(1'b0)) u_slp (
      .clock_in(clock_in), .rst_in(rst_in),
      .d_in(sleep_input_n_in), .q_out(slp_n_s));

   // Internal clear: reset or sleep; sync output resets low so sleep is active at start
   wire asleep = ~slp_n_s;

   reg cs_n_d_ff;
   reg sck_d_ff;
   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         cs_n_d_ff <= 1'b1;
         sck_d_ff  <= 1'b0;
      end else begin
         cs_n_d_ff <= cs_n_s | asleep;
         sck_d_ff  <= sck_s;
      end
   end
   wire cs_n_q   = cs_n_s | asleep;
   wire cs_fall  = cs_n_d_ff & ~cs_n_q;
   wire cs_rise  = ~cs_n_d_ff & cs_n_q;
   wire sck_rise = ~sck_d_ff & sck_s & ~cs_n_q;
   wire sck_fall = sck_d_ff & ~sck_s & ~cs_n_q;

   // ****************************************
   // Serial shifting
   // ****************************************
   reg [15:0] shift_in_ff;
   reg [15:0] shift_out_ff;
   reg [4:0]  bit_cnt_ff;
   reg [15:0] ctrl_ff;
   reg [15:0] status_ff;
   wire [15:0] status_word;

   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         shift_in_ff         <= `SHB_CW_RESET;
         shift_out_ff        <= `SHB_ST_RESET;
         bit_cnt_ff          <= 5'h00;
         serial_out_line_out <= 1'b0;
      end else if (asleep) begin
         shift_in_ff         <= `SHB_CW_RESET;
         shift_out_ff        <= `SHB_ST_RESET;
         bit_cnt_ff          <= 5'h00;
         serial_out_line_out <= 1'b0;
      end else if (cs_fall) begin
         shift_out_ff        <= {status_word[14:0], 1'b0};
         serial_out_line_out <= status_word[15];
         bit_cnt_ff          <= 5'h00;
      end else begin
         // capture on rising edge, MSB first
         if (sck_rise && bit_cnt_ff != 5'h10) begin
            shift_in_ff <= {shift_in_ff[14:0], sdi_s};
            bit_cnt_ff  <= bit_cnt_ff + 5'h01;
         end
         // next status bit on falling edge
         if (sck_fall) begin
            serial_out_line_out <= shift_out_ff[15];
            shift_out_ff        <= {shift_out_ff[14:0], 1'b0};
         end
      end
   end
   assign serial_out_line_oe_out = ~cs_n_q;

   // only a complete sixteen-bit frame programs
   wire load = cs_rise & (bit_cnt_ff == 5'h10);

   // ****************************************
   // Control register
   // ****************************************
   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         ctrl_ff <= `SHB_CW_RESET;
      end else if (asleep) begin
         ctrl_ff <= `SHB_CW_RESET;
      end else if (load) begin
         // take effect at rising chip select
         ctrl_ff <= shift_in_ff;
      end
   end

   wire ocsd_en = ctrl_ff[`SHB_CW_OCSD_BIT];
   wire supply_high_cutoff_en = ctrl_ff[`SHB_CW_SUPPLY_HIGH_CUTOFF_BIT];

   // ****************************************
   // Timers
   // ****************************************
   wire [5:0] ls_cmd;
   wire [5:0] hs_cmd;
   reg  [11:0] cut_ff;
   wire [11:0] oc_in;
   wire [11:0] oc_done;
   wire [5:0]  ls_ready;
   wire        blank_done;
   genvar g;
   generate
      for (g = 0; g < 6; g = g + 1) begin : g_pair
         // odd bits low-side, even bits high-side
         assign ls_cmd[g] = ctrl_ff[2*g+1];
         assign hs_cmd[g] = ctrl_ff[2*g+2];
         assign oc_in[2*g]   = low_side_overcurrent_in[g];
         assign oc_in[2*g+1] = high_side_overcurrent_in[g];
      end
      for (g = 0; g < 12; g = g + 1) begin : g_oc
         // cutoff delay per switch while overcurrent persists
         shb_timer #(.WIDTH(14), .COUNT(OC_CYCLES)) u_oc (
            .clock_in(clock_in), .rst_in(rst_in),
            .start_in(~oc_in[g] | cut_ff[g]), .run_in(~asleep),
            .done_out(oc_done[g]));
      end
      for (g = 0; g < 6; g = g + 1) begin : g_ls
         // low-side waits while its high-side partner was on
         shb_timer #(.WIDTH(10), .COUNT(LS_CYCLES)) u_ls (
            .clock_in(clock_in), .rst_in(rst_in),
            .start_in(high_side_switch_out[g]), .run_in(~asleep),
            .done_out(ls_ready[g]));
      end
   endgenerate

   // blanking restarts on every rising chip select
   shb_timer #(.WIDTH(16), .COUNT(UL_CYCLES)) u_blank (
      .clock_in(clock_in), .rst_in(rst_in), .start_in(cs_rise),
      .run_in(~asleep), .done_out(blank_done));

   // ****************************************
   // Overcurrent cutoff and switch outputs
   // ****************************************
   wire [11:0] sw_cmd = pair_mix(hs_cmd, ls_cmd);
   wire [11:0] oc_trip = oc_in & oc_done & ~cut_ff & sw_cmd & {12{ocsd_en}};
   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         cut_ff <= 12'h000;
      end else if (asleep || load) begin
         // A new programming cycle re-arms every switch
         cut_ff <= 12'h000;
      end else begin
         // only trips while shutdown is enabled
         cut_ff <= cut_ff | oc_trip;
      end
   end

   // ****************************************
   // Switch outputs
   // ****************************************
   wire ov_cut   = supply_high_cutoff_en & supply_over_in;
   wire drive_ok = ~asleep & ~supply_under_in;
   reg  [5:0] nxt_hs;
   reg  [5:0] nxt_ls;
   integer i;
   always @* begin
      nxt_hs = 6'h00;
      nxt_ls = 6'h00;
      for (i = 0; i < 6; i = i + 1) begin
         nxt_hs[i] = hs_cmd[i] & ~cut_ff[2*i+1] & ~ov_cut & drive_ok;
         // Checking the old and the new high side state closes a one-cycle overlap
         nxt_ls[i] = ls_cmd[i] & ~cut_ff[2*i] & ~ov_cut & ls_ready[i] & drive_ok
                     & ~high_side_switch_out[i] & ~nxt_hs[i];
      end
   end

   // Gate commands are registered so a decode glitch never reaches a switch
   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         low_side_switch_out  <= 6'h00;
         high_side_switch_out <= 6'h00;
         driver_enable_out    <= 1'b0;
      end else begin
         // undervoltage or sleep: all switch outputs high impedance
         driver_enable_out    <= drive_ok;
         high_side_switch_out <= nxt_hs;
         low_side_switch_out  <= nxt_ls;
      end
   end

   // ****************************************
   // Status register
   // ****************************************
   // Bits 1 to 12 are not stored; they show the gate commands applied now
   wire [11:0] sw_state = pair_mix(high_side_switch_out, low_side_switch_out);
   wire [11:0] ul_all   = pair_mix(high_side_underload_in, low_side_underload_in);
   wire ul_ev  = |(ul_all & sw_state) & blank_done & ~cs_rise;
   wire ovl_ev = |oc_trip;
   // lockout disabled reports as supply fault
   wire sup_ev = supply_over_in | supply_under_in | ~supply_high_cutoff_en;
   // clear requested by the word being loaded
   wire clr_now = load & shift_in_ff[`SHB_CW_CLR_BIT];
   reg  temp_ff;

   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         status_ff <= `SHB_ST_RESET;
         temp_ff   <= 1'b0;
      end else if (asleep) begin
         status_ff <= `SHB_ST_RESET;
         temp_ff   <= 1'b0;
      end else begin
         // Temperature bit tracks the warning comparator, clears itself
         temp_ff <= temp_prewarn_in;
         // clear after programming unless bit 0 low; new events win
         status_ff[`SHB_ST_OVL_BIT] <= sticky_bit(status_ff[`SHB_ST_OVL_BIT], ovl_ev, clr_now);
         status_ff[`SHB_ST_UNL_BIT] <= sticky_bit(status_ff[`SHB_ST_UNL_BIT], ul_ev, clr_now);
         status_ff[`SHB_ST_SUP_BIT] <= sticky_bit(status_ff[`SHB_ST_SUP_BIT], sup_ev, clr_now);
      end
   end
   assign status_word = {status_ff[`SHB_ST_SUP_BIT], status_ff[`SHB_ST_UNL_BIT],
                         status_ff[`SHB_ST_OVL_BIT], sw_state, temp_ff};
endmodule

//--- verif/shb_core_sva.sv
`timescale 1ns/10ps
module shb_chk #(
   parameter LS_CYCLES = 4
) (
   input wire       clock_in,
   input wire       rst_in,
   input wire       chip_select_line_n_in,
   input wire       serial_clock_in,
   input wire       sleep_input_n_in,
   input wire       supply_under_in,
   input wire       serial_out_line_out,
   input wire       serial_out_line_oe_out,
   input wire [5:0] low_side_switch_out,
   input wire [5:0] high_side_switch_out,
   input wire       driver_enable_out
);
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (rst_in);
   // ****************************************
   // Frame and pin relations
   // ****************************************
   sequence frame_open;
      $fell(chip_select_line_n_in) ##1 (!chip_select_line_n_in) [*5];
   endsequence
   sequence select_idle;
      chip_select_line_n_in [*8];
   endsequence
   chk_oe_frame: assert property (frame_open |-> serial_out_line_oe_out)
      else $error("serial output not driven inside frame");
   chk_oe_release: assert property (select_idle |-> !serial_out_line_oe_out)
      else $error("serial output driven while deselected");
   // Bit stands for six cycles after the serial clock rises inside a frame
   chk_bit_stands: assert property ($rose(serial_clock_in) && serial_out_line_oe_out
      |=> $stable(serial_out_line_out) [*6])
      else $error("serial output moved during high clock phase");
   chk_no_crossover: assert property ((low_side_switch_out & high_side_switch_out) == 6'h00)
      else $error("both switches of a pair on");
   chk_ls_delay: assert property ($rose(low_side_switch_out[0]) |->
      !$past(high_side_switch_out[0]) && !$past(high_side_switch_out[0], LS_CYCLES))
      else $error("low side on too soon after high side");
   chk_load_idle: assert property ($rose(|high_side_switch_out) |->
      chip_select_line_n_in && $past(chip_select_line_n_in, 3))
      else $error("switch turned on before select rose");
   chk_under_off: assert property (supply_under_in [*3] |-> !driver_enable_out)
      else $error("outputs driven during undervoltage");
   chk_sleep_clear: assert property ((!sleep_input_n_in) [*6] |-> !driver_enable_out &&
      low_side_switch_out == 6'h00 && high_side_switch_out == 6'h00)
      else $error("outputs not cleared in sleep");
endmodule
bind shb_core shb_chk #(.LS_CYCLES(LS_CYCLES)) i_chk (
   .clock_in(clock_in), .rst_in(rst_in), .chip_select_line_n_in(chip_select_line_n_in),
   .serial_clock_in(serial_clock_in), .sleep_input_n_in(sleep_input_n_in),
   .supply_under_in(supply_under_in), .serial_out_line_out(serial_out_line_out),
   .serial_out_line_oe_out(serial_out_line_oe_out), .low_side_switch_out(low_side_switch_out),
   .high_side_switch_out(high_side_switch_out), .driver_enable_out(driver_enable_out));

//--- verif/shb_host.sv
`timescale 1ns/10ps
module shb_host (
   input  wire  clock_in,
   input  wire  serial_out_line_in,
   input  wire  serial_out_line_oe_in,
   output logic chip_select_line_n_out,
   output logic serial_clock_out,
   output logic serial_in_line_out
);
   initial begin
      chip_select_line_n_out = 1'b1;
      serial_clock_out = 1'b0;
      serial_in_line_out = 1'b0;
   end
   task tick(input integer n);
      begin
         repeat (n) @(posedge clock_in);
         #1;
      end
   endtask
   // ****************************************
   // Frame of n bits, h clocks per clock half
   // ****************************************
   task xfer(input logic [15:0] w, input integer n, input integer h, output logic [15:0] r);
      integer i;
      begin
         r = 16'h0000;
         tick(h);
         chip_select_line_n_out = 1'b0;
         tick(h);
         for (i = 15; i > 15 - n; i = i - 1) begin
            tick(h / 2);
            // MSB first, changed while clock low
            serial_in_line_out = w[i];
            tick(h / 2);
            serial_clock_out = 1'b1;
            r[i] = serial_out_line_oe_in ? serial_out_line_in : 1'bx;
            tick(h);
            serial_clock_out = 1'b0;
         end
         tick(h);
         chip_select_line_n_out = 1'b1;
         // Released data line must not keep showing the last bit
         serial_in_line_out = ~serial_in_line_out;
      end
   endtask
endmodule

//--- verif/serial_halfbridge_switch_control_bench.sv
`timescale 1ns/10ps
module serial_halfbridge_switch_control_bench;
   logic        clock_in, rst_in = 1'b1, sleep_n = 1'b1, s_over = 1'b0, s_under = 1'b0;
   logic [5:0]  ls_oc = 6'h00, ls_ul = 6'h00, hs_oc = 6'h00, hs_ul = 6'h00;
   logic        temp = 1'b0;
   logic [15:0] r;
   wire         cs_n, sck, di, dout, oe, en;
   wire  [5:0]  ls, hs;
   wire  [15:0] outs = {3'h0, en, hs, ls};
   integer      mismatches = 0, n_tests = 0;
   initial begin
      clock_in = 1'b0;
      forever #2.5 clock_in = ~clock_in;
   end
   // Short counts keep the run small; expectations follow these values
   shb_core #(.OC_CYCLES(20), .UL_CYCLES(40), .LS_CYCLES(4)) i_dut (
      .clock_in(clock_in), .rst_in(rst_in), .chip_select_line_n_in(cs_n),
      .serial_clock_in(sck), .serial_in_line_in(di), .sleep_input_n_in(sleep_n),
      .low_side_overcurrent_in(ls_oc), .high_side_overcurrent_in(hs_oc),
      .low_side_underload_in(ls_ul), .high_side_underload_in(hs_ul), .temp_prewarn_in(temp),
      .supply_over_in(s_over), .supply_under_in(s_under), .serial_out_line_out(dout),
      .serial_out_line_oe_out(oe), .low_side_switch_out(ls), .high_side_switch_out(hs),
      .driver_enable_out(en));
   shb_host i_host (
      .clock_in(clock_in), .serial_out_line_in(dout), .serial_out_line_oe_in(oe),
      .chip_select_line_n_out(cs_n), .serial_clock_out(sck), .serial_in_line_out(di));
   task chk(input logic [15:0] got, input logic [15:0] exp);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task results;
      begin
         $display("comparisons %0d mismatches %0d", n_tests, mismatches);
         if (mismatches == 0 && n_tests > 0) begin
            $display("*** PASS ***");
         end else begin
            $display("*** FAIL ***");
         end
         $finish;
      end
   endtask
   initial begin
      i_host.tick(16);
      rst_in = 1'b0;
      i_host.tick(10);
      i_host.xfer(16'h800c, 16, 16, r);
      i_host.tick(16);
      chk(outs, 16'h1042);
      i_host.xfer(16'h800d, 16, 16, r);
      chk(r & 16'h7fff, 16'h000c);
      // High side 1 off and low side 1 on in one load
      i_host.xfer(16'h800a, 16, 16, r);
      chk(r, 16'h000c);
      i_host.tick(16);
      chk(outs, 16'h1003);
      ls_oc = 6'h01;
      i_host.tick(40);
      chk(outs, 16'h1003);
      i_host.xfer(16'ha00a, 16, 16, r);
      i_host.tick(40);
      chk(outs, 16'h1002);
      ls_oc = 6'h00;
      i_host.xfer(16'ha00b, 16, 16, r);
      chk(r, 16'h2008);
      // Underload inside the blanking time, then after it
      i_host.tick(10);
      ls_ul = 6'h02;
      i_host.tick(20);
      ls_ul = 6'h00;
      i_host.xfer(16'ha00a, 16, 16, r);
      chk(r, 16'h000a);
      i_host.tick(60);
      ls_ul = 6'h02;
      i_host.tick(10);
      ls_ul = 6'h00;
      i_host.xfer(16'h800a, 16, 16, r);
      chk(r, 16'h400a);
      s_over = 1'b1;
      i_host.tick(10);
      chk(outs & 16'h0fff, 16'h0000);
      s_over = 1'b0;
      i_host.xfer(16'h0003, 16, 16, r);
      chk({15'h0000, r[15]}, 16'h0001);
      i_host.xfer(16'h0003, 16, 16, r);
      chk({15'h0000, r[15]}, 16'h0001);
      s_over = 1'b1;
      i_host.tick(20);
      chk(outs, 16'h1001);
      s_over = 1'b0;
      s_under = 1'b1;
      i_host.tick(6);
      chk({15'h0000, en}, 16'h0000);
      s_under = 1'b0;
      sleep_n = 1'b0;
      i_host.tick(8);
      chk(outs, 16'h0000);
      sleep_n = 1'b1;
      i_host.tick(10);
      i_host.xfer(16'h8000, 16, 16, r);
      chk(r, 16'h8000);
      // A frame one bit short must not load
      i_host.xfer(16'h8006, 15, 16, r);
      i_host.tick(16);
      chk(outs, 16'h1000);
      // High side overcurrent trip, temperature warning, high side underload
      i_host.xfer(16'ha004, 16, 16, r);
      hs_oc = 6'h01;
      i_host.tick(40);
      chk(outs, 16'h1000);
      hs_oc = 6'h00;
      temp = 1'b1;
      i_host.xfer(16'ha005, 16, 16, r);
      chk(r, 16'ha001);
      i_host.tick(60);
      hs_ul = 6'h01;
      i_host.tick(10);
      hs_ul = 6'h00;
      temp = 1'b0;
      i_host.xfer(16'h8000, 16, 16, r);
      chk(r, 16'h4004);
      results;
   end
endmodule
